// ==== bld_core_exec.sv ====
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - xor wreg with file, zero flag only
// - bit clear in file, flags untouched
// - bit set in file, flags untouched
// - test bit, skip next when zero
// - test bit, skip next when one
// - add literal to wreg, C DC Z
// - and literal into wreg, zero flag only
// - or literal into wreg, zero flag only
// - xor literal into wreg, zero flag only
// - literal minus wreg into wreg, C DC Z
// - literal to wreg, pop stack, two cycles
// - standby in one cycle, updates TO PD
// - add wreg and file, destination bit, C DC Z
// - and wreg with file, destination bit, Z
// - pc change or true test takes two cycles
// - port read-modify-write uses pin levels
// - timer zero write clears assigned prescaler
// - call pushes return, loads page and literal
// - instruction cycle is four oscillator periods
module bld_core_exec (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [13:0] instr,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  file_rdata,
  input  wire logic [7:0]  pin_rdata,
  input  wire logic [4:0]  program_page_latch,
  input  wire logic        prescaler_on_timer,
  input  wire logic        wake,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic      [12:0] pc,
  output logic      [7:0]  wreg,
  output logic             file_we,
  output logic      [6:0]  file_waddr,
  output logic      [7:0]  file_wdata,
  output logic             prescaler_clear,
  output logic             watchdog_clear,
  output logic             standby,
  output logic             exec_done
);
  typedef struct packed {
    logic [7:0]        w;
    logic              c;
    logic              dc;
    logic              z;
    logic              timeout_flag;
    logic              powerdown_flag;
    logic [12:0]       pc;
    logic [bld_pkg::STACK_DEPTH-1:0][12:0] stack;
    logic [2:0]        sp;
    logic              nop_next;
    logic              sleeping;
    logic              run;
    logic              file_we;
    logic [6:0]        file_waddr;
    logic [7:0]        file_wdata;
    logic              psc_clear;
    logic              wdt_clear;
    logic              exec_done;
    logic [15:0]       rdata;
  } bld_state_t;

  bld_state_t s;
  bld_state_t next_s;

  bld_phase_if ph ();

  bld_phase_gen u_phase (
    .clk  (clk),
    .srst (srst),
    .ph   (ph)
  );

  // Sum with carry out and nibble carry, packed as {c, dc, sum}
  function automatic logic [9:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction

  function automatic logic is_port(input logic [6:0] addr);
    return (addr == bld_pkg::ADDR_PORT_A) ||
           (addr == bld_pkg::ADDR_PORT_B);
  endfunction

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    return 8'h01 << idx;
  endfunction

  logic [1:0]  op_cls;
  logic [3:0]  op_sub;
  logic [6:0]  f_addr;
  logic [7:0]  lit;
  logic        dest_file;
  logic [2:0]  bsel;
  logic [7:0]  operand;
  logic        tested;
  logic [12:0] pc_inc;
  logic [12:0] pc_page;
  logic [9:0]  sum_lw;
  logic [9:0]  sum_wf;
  logic [9:0]  diff_lw;
  logic [7:0]  file_res;
  logic        file_op;

  always_comb begin
    op_cls    = instr[13:12];
    op_sub    = instr[11:8];
    f_addr    = instr[6:0];
    lit       = instr[7:0];
    dest_file = instr[bld_pkg::DEST_BIT];
    bsel      = instr[9:7];
    // Ports read back the pin levels, not the output latch
    operand   = is_port(f_addr) ? pin_rdata : file_rdata;
    tested    = operand[bsel];
    pc_inc    = s.pc + 13'h0001;
    pc_page   = {program_page_latch[bld_pkg::PAGE_HI:bld_pkg::PAGE_LO],
                 instr[10:0]};
    sum_lw    = add8(s.w, lit, 1'b0);
    sum_wf    = add8(s.w, operand, 1'b0);
    // Literal minus wreg as literal plus inverted wreg plus one
    diff_lw   = add8(lit, ~s.w, 1'b1);
    file_res  = 8'h00;
    file_op   = 1'b0;

    next_s = s;
    next_s.file_we   = 1'b0;
    next_s.psc_clear = 1'b0;
    next_s.wdt_clear = 1'b0;
    next_s.exec_done = 1'b0;
    next_s.rdata     = 16'h0000;

    // Read data lives for one cycle only, so an old value never lingers
    if (reg_rd) begin
      unique case (reg_addr)
        bld_pkg::RB_WREG:   next_s.rdata = {8'h00, s.w};
        bld_pkg::RB_STATUS: begin
          next_s.rdata[bld_pkg::ST_C]     = s.c;
          next_s.rdata[bld_pkg::ST_DC]    = s.dc;
          next_s.rdata[bld_pkg::ST_Z]     = s.z;
          next_s.rdata[bld_pkg::ST_PD]    = s.powerdown_flag;
          next_s.rdata[bld_pkg::ST_TO]    = s.timeout_flag;
          next_s.rdata[bld_pkg::ST_SLEEP] = s.sleeping;
          next_s.rdata[bld_pkg::ST_SP_LO +: 3] = s.sp;
        end
        bld_pkg::RB_PC:     next_s.rdata = {3'h0, s.pc};
        bld_pkg::RB_CTRL:   next_s.rdata = {15'h0000, s.run};
        default:            next_s.rdata = 16'h0000;
      endcase
    end

    // Software writes first, so an executing instruction overrides them
    if (reg_wr) begin
      unique case (reg_addr)
        bld_pkg::RB_WREG:   next_s.w = reg_wdata[7:0];
        bld_pkg::RB_STATUS: begin
          next_s.c  = reg_wdata[bld_pkg::ST_C];
          next_s.dc = reg_wdata[bld_pkg::ST_DC];
          next_s.z  = reg_wdata[bld_pkg::ST_Z];
        end
        bld_pkg::RB_CTRL: begin
          next_s.run = reg_wdata[bld_pkg::CTRL_RUN];
          if (reg_wdata[bld_pkg::CTRL_WAKE]) begin
            next_s.sleeping = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Wake is applied ahead of execution, so a standby word in the same
    // cycle still wins and the core goes to sleep
    if (wake) begin
      next_s.sleeping = 1'b0;
    end

    // Commit only on the last phase: the word has three clocks to settle,
    // and a halted or sleeping core leaves pc where software can read it
    if (ph.cycle_end && s.run && !s.sleeping && instr_valid) begin
      if (s.nop_next) begin
        // Second cycle of a two-cycle instruction: nothing is consumed
        next_s.nop_next = 1'b0;
      end else begin
        next_s.exec_done = 1'b1;
        next_s.pc = pc_inc;
        unique case (op_cls)
          bld_pkg::CLS_FILE: begin
            if (instr == bld_pkg::OPW_STANDBY) begin
              next_s.timeout_flag   = 1'b1;
              next_s.powerdown_flag = 1'b0;
              next_s.sleeping       = 1'b1;
              // Entering standby restarts the watchdog as well
              next_s.wdt_clear      = 1'b1;
            end else if (instr == bld_pkg::OPW_WDT_CLR) begin
              next_s.timeout_flag   = 1'b1;
              next_s.powerdown_flag = 1'b1;
              next_s.wdt_clear      = 1'b1;
            end else if (instr == bld_pkg::OPW_RETURN) begin
              next_s.sp       = s.sp - 3'h1;
              next_s.pc       = s.stack[s.sp - 3'h1];
              next_s.nop_next = 1'b1;
            end else if (op_sub == bld_pkg::SUB_XOR_F) begin
              file_res = s.w ^ operand;
              file_op  = 1'b1;
              next_s.z = (file_res == 8'h00);
            end else if (op_sub == bld_pkg::SUB_AND_F) begin
              file_res = s.w & operand;
              file_op  = 1'b1;
              next_s.z = (file_res == 8'h00);
            end else if (op_sub == bld_pkg::SUB_ADD_F) begin
              file_res  = sum_wf[7:0];
              file_op   = 1'b1;
              next_s.c  = sum_wf[9];
              next_s.dc = sum_wf[8];
              next_s.z  = (sum_wf[7:0] == 8'h00);
            end
            if (file_op) begin
              if (dest_file) begin
                next_s.file_we    = 1'b1;
                next_s.file_waddr = f_addr;
                next_s.file_wdata = file_res;
                if ((f_addr == bld_pkg::ADDR_TIMER0) &&
                    prescaler_on_timer) begin
                  next_s.psc_clear = 1'b1;
                end
              end else begin
                next_s.w = file_res;
              end
            end
          end
          bld_pkg::CLS_BIT: begin
            unique case (instr[11:10])
              bld_pkg::SUB_BCLR, bld_pkg::SUB_BSET: begin
                next_s.file_we    = 1'b1;
                next_s.file_waddr = f_addr;
                if (instr[11:10] == bld_pkg::SUB_BCLR) begin
                  next_s.file_wdata = operand & ~bit_mask(bsel);
                end else begin
                  next_s.file_wdata = operand | bit_mask(bsel);
                end
                if ((f_addr == bld_pkg::ADDR_TIMER0) &&
                    prescaler_on_timer) begin
                  next_s.psc_clear = 1'b1;
                end
              end
              bld_pkg::SUB_BTSC: begin
                if (!tested) begin
                  // Step over the next word now; the idle slot keeps pc
                  next_s.pc       = s.pc + 13'h0002;
                  next_s.nop_next = 1'b1;
                end
              end
              bld_pkg::SUB_BTSS: begin
                if (tested) begin
                  next_s.pc       = s.pc + 13'h0002;
                  next_s.nop_next = 1'b1;
                end
              end
            endcase
          end
          bld_pkg::CLS_JUMP: begin
            next_s.pc       = pc_page;
            next_s.nop_next = 1'b1;
            if (!instr[bld_pkg::JUMP_SEL_BIT]) begin
              // Eight deep with no overflow check: a ninth nested call
              // overwrites the oldest return address
              next_s.stack[s.sp] = pc_inc;
              next_s.sp          = s.sp + 3'h1;
            end
          end
          bld_pkg::CLS_LIT: begin
            if (op_sub[3:1] == bld_pkg::SUB_ADD_L) begin
              next_s.w  = sum_lw[7:0];
              next_s.c  = sum_lw[9];
              next_s.dc = sum_lw[8];
              next_s.z  = (sum_lw[7:0] == 8'h00);
            end else if (op_sub[3:1] == bld_pkg::SUB_SUB_L) begin
              next_s.w  = diff_lw[7:0];
              next_s.c  = diff_lw[9];
              next_s.dc = diff_lw[8];
              next_s.z  = (diff_lw[7:0] == 8'h00);
            end else if (op_sub == bld_pkg::SUB_AND_L) begin
              next_s.w = s.w & lit;
              next_s.z = ((s.w & lit) == 8'h00);
            end else if (op_sub == bld_pkg::SUB_OR_L) begin
              next_s.w = s.w | lit;
              next_s.z = ((s.w | lit) == 8'h00);
            end else if (op_sub == bld_pkg::SUB_XOR_L) begin
              next_s.w = s.w ^ lit;
              next_s.z = ((s.w ^ lit) == 8'h00);
            end else if (op_sub[3:2] == bld_pkg::SUB_RETURN_WITH_LITERAL) begin
              next_s.w        = lit;
              next_s.sp       = s.sp - 3'h1;
              next_s.pc       = s.stack[s.sp - 3'h1];
              next_s.nop_next = 1'b1;
            end else if (op_sub[3:2] == bld_pkg::SUB_MOVLW) begin
              next_s.w = lit;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s                <= '0;
      s.run            <= bld_pkg::RST_RUN;
      s.timeout_flag   <= bld_pkg::RST_TO;
      s.powerdown_flag <= bld_pkg::RST_PD;
      s.pc             <= bld_pkg::RST_PC;
    end else begin
      s <= next_s;
    end
  end

  // Every output is a field of the registered state
  assign reg_rdata       = s.rdata;
  assign pc              = s.pc;
  assign wreg            = s.w;
  assign file_we         = s.file_we;
  assign file_waddr      = s.file_waddr;
  assign file_wdata      = s.file_wdata;
  assign prescaler_clear = s.psc_clear;
  assign watchdog_clear  = s.wdt_clear;
  assign standby         = s.sleeping;
  assign exec_done       = s.exec_done;
endmodule

// ==== bld_pkg.sv ====
package bld_pkg;
  // Opcode classes, instruction bits 13:12
  localparam logic [1:0]  CLS_FILE     = 2'h0;
  localparam logic [1:0]  CLS_BIT      = 2'h1;
  localparam logic [1:0]  CLS_JUMP     = 2'h2;
  localparam logic [1:0]  CLS_LIT      = 2'h3;
  // File class sub-fields, bits 11:8
  localparam logic [3:0]  SUB_XOR_F    = 4'h6;
  localparam logic [3:0]  SUB_AND_F    = 4'h5;
  localparam logic [3:0]  SUB_ADD_F    = 4'h7;
  // Bit class sub-fields, bits 11:10
  localparam logic [1:0]  SUB_BCLR     = 2'h0;
  localparam logic [1:0]  SUB_BSET     = 2'h1;
  localparam logic [1:0]  SUB_BTSC     = 2'h2;
  localparam logic [1:0]  SUB_BTSS     = 2'h3;
  // Literal class sub-fields
  localparam logic [3:0]  SUB_OR_L     = 4'h8;
  localparam logic [3:0]  SUB_AND_L    = 4'h9;
  localparam logic [3:0]  SUB_XOR_L    = 4'ha;
  localparam logic [2:0]  SUB_SUB_L    = 3'h6;
  localparam logic [2:0]  SUB_ADD_L    = 3'h7;
  localparam logic [1:0]  SUB_RETURN_WITH_LITERAL    = 2'h1;
  localparam logic [1:0]  SUB_MOVLW    = 2'h0;
  // Jump class: bit 11 selects absolute jump over call
  localparam int          JUMP_SEL_BIT = 11;
  // Whole-word control encodings
  localparam logic [13:0] OPW_STANDBY  = 14'h0063;
  localparam logic [13:0] OPW_WDT_CLR  = 14'h0064;
  localparam logic [13:0] OPW_RETURN   = 14'h0008;
  // Field positions
  localparam int          DEST_BIT     = 7;
  localparam int          PAGE_HI      = 4;
  localparam int          PAGE_LO      = 3;
  // File addresses with special handling
  localparam logic [6:0]  ADDR_TIMER0  = 7'h01;
  localparam logic [6:0]  ADDR_PORT_A  = 7'h05;
  localparam logic [6:0]  ADDR_PORT_B  = 7'h06;
  // Register port map
  localparam logic [3:0]  RB_WREG      = 4'h0;
  localparam logic [3:0]  RB_STATUS    = 4'h1;
  localparam logic [3:0]  RB_PC        = 4'h2;
  localparam logic [3:0]  RB_CTRL      = 4'h3;
  // Status field positions
  localparam int          ST_C         = 0;
  localparam int          ST_DC        = 1;
  localparam int          ST_Z         = 2;
  localparam int          ST_PD        = 3;
  localparam int          ST_TO        = 4;
  localparam int          ST_SLEEP     = 5;
  localparam int          ST_SP_LO     = 8;
  // Control field positions
  localparam int          CTRL_RUN     = 0;
  localparam int          CTRL_WAKE    = 1;
  // Reset values and sizes
  localparam logic        RST_RUN      = 1'b1;
  localparam logic        RST_TO       = 1'b1;
  localparam logic        RST_PD       = 1'b1;
  localparam logic [12:0] RST_PC       = 13'h0000;
  localparam int          STACK_DEPTH  = 8;
  localparam logic [1:0]  LAST_PHASE   = 2'h3;
endpackage

// ==== bld_phase_if.sv ====
`timescale 1ns/1ps
interface bld_phase_if;
  logic [1:0] phase;
  logic       cycle_end;
  modport gen (output phase, output cycle_end);
  modport use_ (input phase, input cycle_end);
endinterface

// ==== bld_phase_gen.sv ====
`timescale 1ns/1ps
module bld_phase_gen (
  input  wire logic    clk,
  input  wire logic    srst,
  bld_phase_if.gen     ph
);
  typedef struct packed {
    logic [1:0] phase;
  } bld_phase_st_t;

  bld_phase_st_t s;
  bld_phase_st_t next_s;

  // Four oscillator periods make one instruction cycle
  always_comb begin
    next_s = s;
    next_s.phase = s.phase + 2'h1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ph.phase = s.phase;
  assign ph.cycle_end = (s.phase == bld_pkg::LAST_PHASE);
endmodule

// ==== bld_core_exec_sva.sv ====
`timescale 1ns/1ps
module bld_core_exec_sva (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [13:0] instr,
  input wire logic [7:0]  file_rdata,
  input wire logic [7:0]  pin_rdata,
  input wire logic [4:0]  program_page_latch,
  input wire logic        prescaler_on_timer,
  input wire logic [12:0] pc,
  input wire logic [7:0]  wreg,
  input wire logic        file_we,
  input wire logic [6:0]  file_waddr,
  input wire logic [7:0]  file_wdata,
  input wire logic        prescaler_clear,
  input wire logic        watchdog_clear,
  input wire logic        standby,
  input wire logic        exec_done
);
  logic [13:0] iq;
  logic [7:0]  fq;
  logic [7:0]  wq;
  logic [1:0]  pgq;
  logic        psq;
  always_ff @(posedge clk) begin
    iq <= instr;
    wq <= wreg;
    pgq <= program_page_latch[4:3];
    psq <= prescaler_on_timer;
    // Port operands are the pin levels, not the latch
    fq <= (instr[6:0] == bld_pkg::ADDR_PORT_A ||
           instr[6:0] == bld_pkg::ADDR_PORT_B) ? pin_rdata : file_rdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_did(logic [13:0] m, logic [13:0] v);
    exec_done && (iq & m) == v;
  endsequence
  sequence s_nop_slot;
    !exec_done [*7];
  endsequence
  chk_bit_clear: assert property (
    s_did(14'h3c00, 14'h1000) |-> file_we && file_waddr == iq[6:0]
    && file_wdata == (fq & ~(8'h01 << iq[9:7])))
    else $error("bit clear wrote a wrong value");
  chk_bit_set: assert property (
    s_did(14'h3c00, 14'h1400) |-> file_we
    && file_wdata == (fq | (8'h01 << iq[9:7])))
    else $error("bit set wrote a wrong value");
  chk_skip_nop: assert property (
    s_did(14'h3800, 14'h1800) ##0 fq[iq[9:7]] == iq[10] |=> s_nop_slot)
    else $error("taken skip did not leave an idle slot");
  chk_jump_pc: assert property (
    s_did(14'h3800, 14'h2800) |-> pc == {pgq, iq[10:0]} ##1 s_nop_slot)
    else $error("jump target or idle slot wrong");
  chk_call_pc: assert property (
    s_did(14'h3800, 14'h2000) |-> pc == {pgq, iq[10:0]} ##1 s_nop_slot)
    else $error("call target or idle slot wrong");
  chk_return_with_literal_wreg: assert property (
    s_did(14'h3c00, 14'h3400) |-> wreg == iq[7:0] ##1 s_nop_slot)
    else $error("return literal wrong");
  chk_add_lit: assert property (
    s_did(14'h3e00, 14'h3e00) |-> wreg == wq + iq[7:0])
    else $error("literal add wrong");
  chk_and_lit: assert property (
    s_did(14'h3f00, 14'h3900) |-> wreg == (wq & iq[7:0]))
    else $error("literal and wrong");
  chk_or_lit: assert property (
    s_did(14'h3f00, 14'h3800) |-> wreg == (wq | iq[7:0]))
    else $error("literal or wrong");
  chk_xor_lit: assert property (
    s_did(14'h3f00, 14'h3a00) |-> wreg == (wq ^ iq[7:0]))
    else $error("literal xor wrong");
  chk_sub_lit: assert property (
    s_did(14'h3e00, 14'h3c00) |-> wreg == iq[7:0] - wq)
    else $error("literal subtract wrong");
  chk_xor_file: assert property (
    s_did(14'h3f80, 14'h0600) |-> wreg == (wq ^ fq))
    else $error("file xor wrong");
  chk_standby_entry: assert property (
    s_did(14'h3fff, 14'h0063) |-> standby && watchdog_clear)
    else $error("standby not entered");
  chk_wdt_pulse: assert property (
    s_did(14'h3fff, 14'h0064) |-> watchdog_clear ##1 !watchdog_clear)
    else $error("watchdog clear pulse wrong");
  chk_timer_clear: assert property (
    exec_done && file_we && file_waddr == bld_pkg::ADDR_TIMER0 && psq
    |-> prescaler_clear)
    else $error("prescaler not cleared");
  chk_cycle_gap: assert property (
    exec_done |=> !exec_done [*3])
    else $error("instructions closer than four clocks");
endmodule

bind bld_core_exec bld_core_exec_sva u_bld_core_exec_sva (
  .clk(clk), .srst(srst), .instr(instr), .file_rdata(file_rdata),
  .pin_rdata(pin_rdata), .program_page_latch(program_page_latch),
  .prescaler_on_timer(prescaler_on_timer), .pc(pc), .wreg(wreg),
  .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
  .prescaler_clear(prescaler_clear), .watchdog_clear(watchdog_clear),
  .standby(standby), .exec_done(exec_done));

// ==== bld_file_model.sv ====
`timescale 1ns/1ps
module bld_file_model (
  input  wire logic        clk,
  input  wire logic [13:0] instr,
  input  wire logic        file_we,
  input  wire logic [6:0]  file_waddr,
  input  wire logic [7:0]  file_wdata,
  output logic      [7:0]  file_rdata,
  output logic      [7:0]  pin_rdata
);
  logic [7:0] regs [128];
  initial begin
    for (int i = 0; i < 128; i++) begin
      regs[i] = 8'(i * 37 + 11);
    end
  end
  assign file_rdata = regs[instr[6:0]];
  // Outside devices pull every pin against the latch, so a slip shows
  assign pin_rdata = ~regs[instr[6:0]];
  always @(posedge clk) begin
    if (file_we) begin
      regs[file_waddr] <= file_wdata;
    end
  end
endmodule

// ==== bld_core_exec_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  num_errors++; $display("ERROR %s expected %h seen %h", nm, ex, got); \
  end end
module bld_core_exec_tb;
  localparam logic [13:0] BASE [16] = '{14'h0600, 14'h0500, 14'h0700,
    14'h1000, 14'h1400, 14'h1800, 14'h1c00, 14'h3e00, 14'h3900, 14'h3800,
    14'h3a00, 14'h3c00, 14'h3400, 14'h2000, 14'h2800, 14'h0064};
  localparam logic [13:0] MSK [16] = '{14'h00ff, 14'h00ff, 14'h00ff,
    14'h03ff, 14'h03ff, 14'h03ff, 14'h03ff, 14'h01ff, 14'h00ff, 14'h00ff,
    14'h00ff, 14'h01ff, 14'h03ff, 14'h07ff, 14'h07ff, 14'h0000};
  logic        clk = 0, srst = 1, instr_valid = 0, wake = 0;
  logic        prescaler_on_timer = 0, reg_wr = 0, reg_rd = 0;
  logic [13:0] instr = 14'h0000;
  logic [4:0]  program_page_latch = 5'h00;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [12:0] pc, epc = 13'h0000, stk [$];
  logic [7:0]  wreg, file_rdata, pin_rdata, file_wdata, ew = 8'h00;
  logic [7:0]  fexp [128];
  logic [6:0]  file_waddr;
  logic        file_we, prescaler_clear, watchdog_clear, standby, exec_done;
  logic        ec = 0, edc = 0, ez = 0, eto = 1, epd = 1, nop = 0;
  logic [1:0]  tph = 2'h0;
  int          num_errors = 0, n_compared = 0, cycles = 0;
  bld_core_exec u_bld_core_exec (.clk(clk), .srst(srst), .instr(instr),
    .instr_valid(instr_valid), .file_rdata(file_rdata),
    .pin_rdata(pin_rdata), .program_page_latch(program_page_latch),
    .prescaler_on_timer(prescaler_on_timer), .wake(wake),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc(pc), .wreg(wreg),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .prescaler_clear(prescaler_clear), .watchdog_clear(watchdog_clear),
    .standby(standby), .exec_done(exec_done));
  bld_file_model u_bld_file_model (.clk(clk), .instr(instr),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .file_rdata(file_rdata), .pin_rdata(pin_rdata));
  always #10 clk = ~clk;
  // Mirrors the core's phase so waits land on the executing edge
  always @(posedge clk) tph <= srst ? 2'h0 : tph + 2'h1;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic exec(input logic [13:0] ins);
    logic [7:0]  f, r, x;
    logic [8:0]  s;
    logic [4:0]  h, pg;
    logic [12:0] npc;
    logic [15:0] st;
    logic [6:0]  a;
    logic        ps, wdt, sb, idle, fw, ww;
    a = ins[6:0];
    pg = 5'($urandom);
    ps = 1'($urandom);
    instr <= ins;
    instr_valid <= 1'b1;
    program_page_latch <= pg;
    prescaler_on_timer <= ps;
    #1 f = (a == bld_pkg::ADDR_PORT_A || a == bld_pkg::ADDR_PORT_B) ?
      pin_rdata : fexp[a];
    x = ins[13] ? ins[7:0] : f;
    s = {1'b0, ew} + {1'b0, x};
    h = {1'b0, ew[3:0]} + {1'b0, x[3:0]};
    {r, wdt, sb, idle, nop} = {8'h00, 4'b0000 | {2'b00, nop, 1'b0}};
    npc = idle ? epc : epc + 13'h1;
    if (!idle) casez (ins)
      14'b000110????????, 14'b111010????????: r = ew ^ x;
      14'b000101????????, 14'b111001????????: r = ew & x;
      14'b111000????????: r = ew | x;
      14'b000111????????, 14'b11111?????????:
        {ec, edc, r} = {s[8], h[4], s[7:0]};
      14'b11110?????????: {ec, edc, r} = {x >= ew, x[3:0] >= ew[3:0], x - ew};
      14'b0100??????????: r = x & ~(8'h01 << ins[9:7]);
      14'b0101??????????: r = x | (8'h01 << ins[9:7]);
      14'b011???????????: begin
        nop = x[ins[9:7]] == ins[10];
        npc = npc + 13'(nop);
      end
      14'b100???????????: begin
        stk.push_back(npc);
        {npc, nop} = {pg[4:3], ins[10:0], 1'b1};
      end
      14'b101???????????: {npc, nop} = {pg[4:3], ins[10:0], 1'b1};
      14'b1101??????????: {r, npc, nop} = {ins[7:0], stk.pop_back(), 1'b1};
      14'h0008: {npc, nop} = {stk.pop_back(), 1'b1};
      14'h0063: {sb, wdt, eto, epd} = 4'b1110;
      14'h0064: {wdt, eto, epd} = 3'b111;
      default: ;
    endcase
    fw = !idle && (ins[13:11] == 3'b010 ||
      (ins[13:12] == 2'b00 && ins[11:8] != 4'h0 && ins[7]));
    ww = !idle && (ins[13:12] == 2'b11 ||
      (ins[13:12] == 2'b00 && ins[11:8] != 4'h0 && !ins[7]));
    if (!idle && ((ins[13:12] == 2'b00 && ins[11:8] != 4'h0) ||
      (ins[13:12] == 2'b11 && ins[11:10] != 2'b01))) ez = r == 8'h00;
    if (ww) ew = r;
    if (fw) fexp[a] = r;
    epc = npc;
    do begin
      @(posedge clk);
      #1;
    end while (tph != 2'h0);
    instr_valid <= 1'b0;
    `CHK("done", !idle, exec_done)
    `CHK("pc", npc, pc)
    `CHK("wreg", ew, wreg)
    `CHK("we", fw, file_we)
    if (fw) `CHK("wdata", {a, r}, {file_waddr, file_wdata})
    `CHK("psc", fw && a == 7'h01 && ps, prescaler_clear)
    `CHK("wdt", wdt, watchdog_clear)
    `CHK("sleep", sb, standby)
    rd(bld_pkg::RB_STATUS, st);
    `CHK("flags", {eto, epd, ez, edc, ec}, st[4:0])
  endtask
  initial begin
    logic [15:0] d;
    logic [13:0] ins;
    int          k;
    void'($urandom(32'h5a46eef7));
    for (int i = 0; i < 128; i++) fexp[i] = 8'(i * 37 + 11);
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    wr(bld_pkg::RB_STATUS, 16'h0000);
    rd(bld_pkg::RB_STATUS, d);
    `CHK("status", 6'h18, d[5:0])
    rd(4'hf, d);
    `CHK("unmapped", 16'h0000, d)
    exec(14'h3800);
    wr(bld_pkg::RB_WREG, 16'h00ff);
    ew = 8'hff;
    exec(14'h3e01);
    exec(14'h3c00);
    exec(14'h1786);
    exec(14'h1005);
    exec(14'h0781);
    exec(14'h1c06);
    exec(14'h0000);
    exec(14'h2155);
    exec(14'h0000);
    exec(14'h34a5);
    exec(14'h2155);
    exec(14'h0000);
    exec(14'h0008);
    exec(14'h0000);
    exec(14'h2fff);
    exec(14'h0000);
    wr(bld_pkg::RB_PC, 16'h0abc);
    rd(bld_pkg::RB_PC, d);
    `CHK("pc_ro", epc, d[12:0])
    for (int j = 0; j < 2; j++) begin
      exec(14'h0063);
      if (j == 0) begin
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        #1;
      end else wr(bld_pkg::RB_CTRL, 16'h0003);
      `CHK("awake", 1'b0, standby)
      exec(14'h0064);
    end
    for (int i = 0; i < 400; i++) begin
      k = $urandom_range(0, 15);
      if (k == 12 && stk.size() == 0 || k == 13 && stk.size() > 6) k = 14;
      ins = BASE[k] | (14'($urandom) & MSK[k]);
      exec(ins);
    end
    end_of_test();
  end
endmodule
